// ### core/ccs_pkg.sv
package ccs_pkg;

  // ----------------------------------------------------------------
  // Machine cycle timing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CCS_S1, CCS_S2, CCS_S3, CCS_S4, CCS_S5, CCS_S6
  } ccs_state_t;

  localparam int CCS_STATE_PERIODS = 2;
  localparam int CCS_CYCLE_STATES  = 6;
  localparam int CCS_CYCLE_PERIODS = CCS_STATE_PERIODS * CCS_CYCLE_STATES;
  localparam int CCS_ADDR_W        = 16;
  localparam logic [1:0]  CCS_XMOVE_CYCLES = 2'h2;
  localparam logic [15:0] CCS_PC_RESET     = 16'h0000;

  // ----------------------------------------------------------------
  // Register space map, index order of the register array
  // ----------------------------------------------------------------
  localparam int CCS_NREG  = 48;
  localparam int CCS_IDX_W = 6;
  localparam logic [7:0] CCS_SPACE_BASE = 8'h80;
  localparam logic [7:0] CCS_REG_ADDR [CCS_NREG] = '{
    8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8a,
    8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h91, 8'h93, 8'h94, 8'h95,
    8'h96, 8'h97, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'ha0, 8'ha1,
    8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'haa,
    8'hab, 8'hae, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb7,
    8'hb8, 8'hc0, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd
  };

  // Indexes the block logic refers to
  localparam logic [5:0] CCS_IDX_PORT0  = 6'h00;
  localparam logic [5:0] CCS_IDX_STACK  = 6'h01;
  localparam logic [5:0] CCS_IDX_DPLOW  = 6'h02;
  localparam logic [5:0] CCS_IDX_DPHIGH = 6'h03;
  localparam logic [5:0] CCS_IDX_PORT1  = 6'h0b;
  localparam logic [5:0] CCS_IDX_CONV   = 6'h10;
  localparam logic [5:0] CCS_IDX_PORT2  = 6'h16;
  localparam logic [5:0] CCS_IDX_PORT3  = 6'h22;
  localparam logic [5:0] CCS_IDX_PORT4  = 6'h29;

  // Reset values
  localparam logic [7:0] CCS_RST_PORT  = 8'hff;
  localparam logic [7:0] CCS_RST_STACK = 8'h07;
  localparam logic [7:0] CCS_RST_ZERO  = 8'h00;

endpackage

// ### core/ccs_seq.sv
`timescale 1ns/100ps
module ccs_seq
  import ccs_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rstn,
  output ccs_state_t state_r,
  output logic       phase_r
);

  localparam int CYC = CCS_CYCLE_PERIODS;

  // ----------------------------------------------------------------
  // Phase and state counters
  // ----------------------------------------------------------------
  // Phase toggles every period, two phases to a state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  // State steps on the second phase, six states to a cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= CCS_S1;
    end else if (phase_r) begin
      unique case (state_r)
        CCS_S1: state_r <= CCS_S2;
        CCS_S2: state_r <= CCS_S3;
        CCS_S3: state_r <= CCS_S4;
        CCS_S4: state_r <= CCS_S5;
        CCS_S5: state_r <= CCS_S6;
        CCS_S6: state_r <= CCS_S1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  cycle_length_a: assert property (
    (state_r == CCS_S1 && !phase_r) |-> ##CYC
    (state_r == CCS_S1 && !phase_r) && $past(state_r) == CCS_S6)
    else $error("machine cycle is not twelve periods");

  state_halves_a: assert property (
    !phase_r |=> phase_r && $stable(state_r) ##1 !phase_r
    && $changed(state_r))
    else $error("state does not last two phases");

endmodule

// ### core/ccs_cycle_sfr.sv
`timescale 1ns/100ps
// Summary of operation
// - Every machine cycle is six states, twelve clock periods in all.
// - Each state has a first and second phase of one period each.
// - Two code fetches occur in every machine cycle but the second of an external move, needed or not.
// - An unneeded fetched byte is dropped and the counter does not advance.
// - Opcode latched in state two, refetch in state four, done at state six.
// - External data move takes two cycles, second cycle has no code fetch.
// - Fetches are skipped only in that second cycle of an external move.
// - Decrement-branch decrements, then branches only if result nonzero.
// - Unoccupied register addresses read zero and ignore writes.
// - Registers at addresses with low three bits zero are bit addressable.
// - Memory bus: 16-bit address, 8-bit data, rd, wr, strobe, latch, reset.
module ccs_cycle_sfr
  import ccs_pkg::*;
#(
  parameter int ADDR_W = CCS_ADDR_W
)(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [1:0]        dec_bytes,
  input  wire logic [1:0]        dec_cycles,
  input  wire logic              dec_xmove,
  input  wire logic              dec_xwrite,
  input  wire logic              dec_decrement_branch_nonzero,
  input  wire logic [7:0]        decrement_branch_nonzero_value,
  input  wire logic [7:0]        xwrite_data,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_rd,
  input  wire logic              reg_wr,
  input  wire logic              reg_bit,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              conv_load,
  input  wire logic [7:0]        conv_data,
  input  wire logic [7:0]        mem_din,
  output ccs_state_t             cyc_state_r,
  output logic                   cyc_phase_r,
  output logic [7:0]             ir_r,
  output logic [7:0]             opnd_r,
  output logic [ADDR_W-1:0]      pc_r,
  output logic                   instr_done_r,
  output logic [7:0]             decrement_branch_nonzero_result_r,
  output logic                   decrement_branch_nonzero_taken_r,
  output logic [7:0]             xread_r,
  output logic [7:0]             reg_rdata_r,
  output logic                   reg_hit_r,
  output logic [15:0]            mem_addr_r,
  output logic [7:0]             mem_dout_r,
  output logic                   mem_doe_r,
  output logic                   mem_rd_n_r,
  output logic                   mem_wr_n_r,
  output logic                   code_read_strobe_n_r,
  output logic                   mem_ale_r,
  output logic                   mem_reset_n_r
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_width
    $error("ADDR_W must lie between 9 and 16");
  end

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  // Finds the register at an address, hit flag on top
  function automatic logic [CCS_IDX_W:0] find_reg(input logic [7:0] a);
    logic [CCS_IDX_W:0] r;
    r = '0;
    for (int i = 0; i < CCS_NREG; i++) begin
      if (CCS_REG_ADDR[i] == a) begin
        r = {1'b1, CCS_IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // Reset value of each register
  function automatic logic [7:0] rst_val(input logic [5:0] i);
    logic [7:0] v;
    v = CCS_RST_ZERO;
    if (i == CCS_IDX_PORT0 || i == CCS_IDX_PORT1 || i == CCS_IDX_PORT2 ||
        i == CCS_IDX_PORT3 || i == CCS_IDX_PORT4) begin
      v = CCS_RST_PORT;
    end else if (i == CCS_IDX_STACK) begin
      v = CCS_RST_STACK;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  ccs_seq u_seq (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .state_r (cyc_state_r),
    .phase_r (cyc_phase_r)
  );

  ccs_state_t        st;
  logic              ph;
  logic              first_cyc_r;
  logic [1:0]        cyc_left_r;
  logic [1:0]        bytes_left_r;
  logic              xmove_r;
  logic              xwrite_r;
  logic              decrement_branch_nonzero_r;
  logic              xmove2_r;
  logic [7:0]        xdata_r;
  logic              fetch_on;
  logic              dec_edge;
  logic              cap_edge;
  logic              is_op;
  logic              cap_need;
  logic              cyc_end;
  logic              instr_end;
  logic              ale_nxt;
  logic              xbusy;
  logic [7:0]        decrement_branch_nonzero_dec;
  logic              decrement_branch_nonzero_nz;
  logic [ADDR_W-1:0] rel_ext;
  logic [15:0]       dptr;
  logic [7:0]        regs_r [CCS_NREG];

  // Timing strobes derived from the state and phase
  assign st        = cyc_state_r;
  assign ph        = cyc_phase_r;
  assign fetch_on  = !xmove2_r;
  assign dec_edge  = first_cyc_r && st == CCS_S3 && !ph;
  assign cap_edge  = fetch_on && !ph && (st == CCS_S2 || st == CCS_S5);
  assign is_op     = first_cyc_r && st == CCS_S2;
  assign cap_need  = is_op || bytes_left_r != 2'h0;
  assign cyc_end   = st == CCS_S6 && ph;
  assign instr_end = cyc_end && cyc_left_r == 2'h1;
  assign ale_nxt   = !ph && (st == CCS_S1 || (st == CCS_S4 && fetch_on));
  assign xbusy     = xmove2_r && st != CCS_S1 && st != CCS_S6;
  assign decrement_branch_nonzero_dec  = decrement_branch_nonzero_value - 8'h01;
  assign decrement_branch_nonzero_nz   = decrement_branch_nonzero_dec != 8'h00;
  assign rel_ext   = ADDR_W'({{8{opnd_r[7]}}, opnd_r});

  // ----------------------------------------------------------------
  // Instruction cycle bookkeeping
  // ----------------------------------------------------------------
  // Decode is taken in state three, cycles count down at cycle end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_cyc_r <= 1'b1;
      cyc_left_r  <= 2'h1;
      xmove_r     <= 1'b0;
      xwrite_r    <= 1'b0;
      decrement_branch_nonzero_r      <= 1'b0;
      xmove2_r    <= 1'b0;
      xdata_r     <= 8'h00;
    end else if (dec_edge) begin
      if (dec_xmove) begin
        cyc_left_r <= CCS_XMOVE_CYCLES;
      end else if (dec_cycles == 2'h0) begin
        cyc_left_r <= 2'h1;
      end else begin
        cyc_left_r <= dec_cycles;
      end
      xmove_r  <= dec_xmove;
      xwrite_r <= dec_xwrite;
      decrement_branch_nonzero_r   <= dec_decrement_branch_nonzero;
      xdata_r  <= xwrite_data;
    end else if (cyc_end) begin
      if (instr_end) begin
        first_cyc_r <= 1'b1;
        xmove2_r    <= 1'b0;
      end else begin
        first_cyc_r <= 1'b0;
        cyc_left_r  <= cyc_left_r - 2'h1;
        xmove2_r    <= xmove_r && cyc_left_r == CCS_XMOVE_CYCLES;
      end
    end
  end

  // Code bytes still owed to the instruction
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bytes_left_r <= 2'h0;
    end else if (dec_edge) begin
      bytes_left_r <= (dec_bytes == 2'h0) ? 2'h0 : dec_bytes - 2'h1;
    end else if (instr_end) begin
      bytes_left_r <= 2'h0;
    end else if (cap_edge && !is_op && cap_need) begin
      bytes_left_r <= bytes_left_r - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Fetched bytes and program counter
  // ----------------------------------------------------------------
  // Opcode goes to the instruction register, later bytes to the operand
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ir_r   <= 8'h00;
      opnd_r <= 8'h00;
    end else if (cap_edge && is_op) begin
      ir_r <= mem_din;
    end else if (cap_edge && cap_need) begin
      opnd_r <= mem_din;
    end
  end

  // Counter advances only on a used byte, or takes the branch
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pc_r <= ADDR_W'(CCS_PC_RESET);
    end else if (cap_edge && cap_need) begin
      pc_r <= pc_r + ADDR_W'(1);
    end else if (instr_end && decrement_branch_nonzero_r && decrement_branch_nonzero_nz) begin
      pc_r <= pc_r + rel_ext;
    end
  end

  // Completion pulse and decrement-branch outcome
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      instr_done_r  <= 1'b0;
      decrement_branch_nonzero_taken_r  <= 1'b0;
      decrement_branch_nonzero_result_r <= 8'h00;
    end else begin
      instr_done_r <= instr_end;
      decrement_branch_nonzero_taken_r <= instr_end && decrement_branch_nonzero_r && decrement_branch_nonzero_nz;
      if (instr_end && decrement_branch_nonzero_r) begin
        decrement_branch_nonzero_result_r <= decrement_branch_nonzero_dec;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory module bus
  // ----------------------------------------------------------------
  assign dptr = {regs_r[CCS_IDX_DPHIGH], regs_r[CCS_IDX_DPLOW]};

  // Address latch, code strobe, data read and write strobes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mem_ale_r            <= 1'b0;
      code_read_strobe_n_r <= 1'b1;
      mem_rd_n_r           <= 1'b1;
      mem_wr_n_r           <= 1'b1;
      mem_doe_r            <= 1'b0;
      mem_dout_r           <= 8'h00;
      mem_addr_r           <= 16'h0000;
      mem_reset_n_r        <= 1'b0;
    end else begin
      mem_reset_n_r        <= 1'b1;
      mem_ale_r            <= ale_nxt;
      code_read_strobe_n_r <= !(fetch_on && ph &&
                              (st == CCS_S1 || st == CCS_S4));
      mem_rd_n_r           <= !(xbusy && !xwrite_r);
      mem_wr_n_r           <= !(xbusy && xwrite_r);
      mem_doe_r            <= xbusy && xwrite_r;
      if (xbusy) begin
        mem_dout_r <= xdata_r;
      end
      if (ale_nxt) begin
        mem_addr_r <= xmove2_r ? dptr : 16'(pc_r);
      end
    end
  end

  // External read data taken before the read strobe ends
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      xread_r <= 8'h00;
    end else if (xmove2_r && !xwrite_r && st == CCS_S6 && !ph) begin
      xread_r <= mem_din;
    end
  end

  // ----------------------------------------------------------------
  // Register space
  // ----------------------------------------------------------------
  logic [CCS_NREG*8-1:0]  regs_flat;
  logic [7:0]             acc_addr;
  logic [CCS_IDX_W:0]     lookup;
  logic [CCS_IDX_W-1:0]   acc_idx;
  logic                   acc_hit;
  logic                   wr_hit;
  logic [7:0]             rd_word;

  // Bit access selects the register of its aligned column
  assign acc_addr = reg_bit ? {reg_addr[7:3], 3'h0} : reg_addr;
  assign lookup   = find_reg(acc_addr);
  assign acc_idx  = lookup[CCS_IDX_W-1:0];
  assign acc_hit  = lookup[CCS_IDX_W] && reg_addr >= CCS_SPACE_BASE;
  assign wr_hit   = reg_wr && acc_hit;
  assign rd_word  = acc_hit ? regs_r[acc_idx] : CCS_RST_ZERO;

  // One storage process per register; the converter result is read only
  for (genvar g = 0; g < CCS_NREG; g++) begin : g_reg
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        regs_r[g] <= rst_val(CCS_IDX_W'(g));
      end else if (CCS_IDX_W'(g) == CCS_IDX_CONV) begin
        if (conv_load) begin
          regs_r[g] <= conv_data;
        end
      end else if (wr_hit && acc_idx == CCS_IDX_W'(g)) begin
        if (reg_bit) begin
          regs_r[g][reg_addr[2:0]] <= reg_wdata[0];
        end else begin
          regs_r[g] <= reg_wdata;
        end
      end
    end
    assign regs_flat[g*8 +: 8] = regs_r[g];

    reset_value_a: assert property (
      @(posedge ref_clk) $rose(rstn) |-> regs_r[g] == rst_val(CCS_IDX_W'(g)))
      else $error("register reset value wrong");
  end

  // Read answer one cycle later; unoccupied reads give zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_r <= 8'h00;
      reg_hit_r   <= 1'b0;
    end else begin
      reg_hit_r <= (reg_rd || reg_wr) && acc_hit;
      if (reg_rd) begin
        reg_rdata_r <= reg_bit ? {7'h00, rd_word[reg_addr[2:0]]} : rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence op_latch;
    cap_edge && is_op;
  endsequence

  sequence single_decode;
    dec_edge && dec_cycles == 2'h1 && !dec_xmove;
  endsequence

  sequence xm_read_window;
    !mem_rd_n_r [*8];
  endsequence

  both_fetches_a: assert property (
    (cap_edge) |-> !code_read_strobe_n_r && $past(mem_ale_r))
    else $error("code fetch strobe missing");

  discard_byte_a: assert property (
    (cap_edge && !cap_need) |=> $stable(pc_r) ##1 $stable(pc_r))
    else $error("counter moved on a dropped byte");

  opcode_then_s4_a: assert property (
    op_latch |=> ir_r == $past(mem_din) ##3
    (st == CCS_S4 && !ph) ##1 mem_ale_r)
    else $error("opcode or second fetch out of place");

  single_done_a: assert property (
    op_latch ##2 single_decode |-> ##8 instr_done_r)
    else $error("one-cycle instruction not done at state six");

  xmove_no_fetch_a: assert property (
    xmove2_r |-> code_read_strobe_n_r && (cap_edge == 1'b0))
    else $error("code fetch during external move cycle");

  xmove_read_a: assert property (
    $fell(mem_rd_n_r) |-> xm_read_window ##1 mem_rd_n_r)
    else $error("external read strobe not eight periods");

  skip_only_xmove_a: assert property (
    (!ph && (st == CCS_S2 || st == CCS_S5) && !xmove2_r) |->
    !code_read_strobe_n_r && cap_edge)
    else $error("fetch skipped outside external move");

  decrement_branch_nonzero_branch_a: assert property (
    (instr_end && decrement_branch_nonzero_r) |=>
    decrement_branch_nonzero_taken_r == ($past(decrement_branch_nonzero_value) != 8'h01) &&
    pc_r == $past(pc_r) + (decrement_branch_nonzero_taken_r ? $past(rel_ext) : '0))
    else $error("decrement branch outcome wrong");

  unoccupied_write_a: assert property (
    (reg_wr && !acc_hit && !conv_load) |=> $stable(regs_flat))
    else $error("write to unoccupied address changed state");

  bit_write_a: assert property (
    (wr_hit && reg_bit && acc_idx != CCS_IDX_CONV) |=>
    regs_r[$past(acc_idx)][$past(reg_addr[2:0])] == $past(reg_wdata[0]))
    else $error("bit write did not land");

  decode_range_a: assert property (
    reg_rd |=> reg_hit_r == ($past(reg_addr) >= CCS_SPACE_BASE &&
    CCS_REG_ADDR[$past(acc_idx)] == $past(acc_addr)))
    else $error("register decode wrong");

  bus_exclusive_a: assert property (
    mem_ale_r |-> code_read_strobe_n_r && mem_rd_n_r && mem_wr_n_r)
    else $error("address latch overlaps a strobe");

endmodule

// ### tb/ccs_mem_model.sv
`timescale 1ns/100ps
// ------------------------------
// Memory module partner
// ------------------------------
module ccs_mem_model
  import ccs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_dout,
  input  wire logic        mem_doe,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        code_n,
  input  wire logic        ale,
  output logic      [7:0]  mem_din,
  output logic      [15:0] wr_addr,
  output logic      [7:0]  wr_data
);
  logic [15:0] lat_addr = 16'h0000;
  logic [7:0]  last     = 8'h00;

  // Latch address on the address latch enable, keep the last write for the bench
  always @(posedge ref_clk) begin
    if (ale) begin
      lat_addr <= mem_addr;
    end
    last <= mem_din;
    if (!wr_n && mem_doe) begin
      wr_addr <= lat_addr;
      wr_data <= mem_dout;
    end
  end

  // Data only under a read strobe; a released bus keeps changing
  always_comb begin
    if (!code_n || !rd_n) begin
      mem_din = lat_addr[7:0] ^ 8'h5a;
    end else begin
      mem_din = ~last;
    end
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import ccs_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic       hit;
  } ccs_rrow_t;
  typedef struct {
    logic [1:0] b;
    logic [1:0] c;
    logic       x;
    logic       xw;
    int         per;
    int         str;
    int         xl;
    int         dpc;
  } ccs_irow_t;

  logic        ref_clk     = 1'b0;
  logic        rstn        = 1'b0;
  logic [1:0]  dec_bytes   = 2'h1;
  logic [1:0]  dec_cycles  = 2'h1;
  logic        dec_xmove   = 1'b0;
  logic        dec_xwrite  = 1'b0;
  logic        dec_decrement_branch_nonzero    = 1'b0;
  logic [7:0]  decrement_branch_nonzero_value  = 8'h00;
  logic [7:0]  xwrite_data = 8'hc3;
  logic [7:0]  reg_addr    = 8'h00;
  logic        reg_rd      = 1'b0;
  logic        reg_wr      = 1'b0;
  logic        reg_bit     = 1'b0;
  logic [7:0]  reg_wdata   = 8'h00;
  logic        conv_load   = 1'b0;
  logic [7:0]  conv_data   = 8'h00;
  ccs_state_t  cyc_state_r;
  logic [7:0]  mem_din, ir_r, opnd_r, decrement_branch_nonzero_result_r, xread_r;
  logic [7:0]  reg_rdata_r, mem_dout_r, wr_data, o;
  logic [15:0] pc_r, mem_addr_r, wr_addr, pc0;
  logic        cyc_phase_r, instr_done_r, decrement_branch_nonzero_taken_r, reg_hit_r;
  logic        mem_doe_r, mem_rd_n_r, mem_wr_n_r, code_read_strobe_n_r;
  logic        mem_ale_r, mem_reset_n_r;
  int          errors      = 0;
  int          comparisons = 0;
  int          n_per, n_str, n_xl, n_ph;

  // Register rows: unoccupied places only ever get zeros
  ccs_rrow_t rrows [9] = '{
    '{8'h81, 8'h55, 8'h55, 1'b1}, '{8'h80, 8'ha5, 8'ha5, 1'b1},
    '{8'h82, 8'h34, 8'h34, 1'b1}, '{8'h83, 8'h12, 8'h12, 1'b1},
    '{8'h8d, 8'hff, 8'hff, 1'b1}, '{8'hcd, 8'h77, 8'h77, 1'b1},
    '{8'h96, 8'h12, 8'h00, 1'b1}, '{8'h84, 8'h00, 8'h00, 1'b0},
    '{8'hff, 8'h00, 8'h00, 1'b0}
  };
  // Instruction rows: bytes, cycles, moves, periods, fetches, pc step
  ccs_irow_t irows [7] = '{
    '{2'h1, 2'h1, 1'b0, 1'b0, 12, 2, 0, 1},
    '{2'h2, 2'h1, 1'b0, 1'b0, 12, 2, 0, 2},
    '{2'h3, 2'h2, 1'b0, 1'b0, 24, 4, 0, 3},
    '{2'h1, 2'h2, 1'b0, 1'b0, 24, 4, 0, 1},
    '{2'h0, 2'h0, 1'b0, 1'b0, 12, 2, 0, 1},
    '{2'h1, 2'h1, 1'b1, 1'b0, 24, 2, 8, 1},
    '{2'h1, 2'h1, 1'b1, 1'b1, 24, 2, 8, 1}
  };

  ccs_cycle_sfr ccs_cycle_sfr_inst (
    .ref_clk, .rstn, .dec_bytes, .dec_cycles, .dec_xmove, .dec_xwrite,
    .dec_decrement_branch_nonzero, .decrement_branch_nonzero_value, .xwrite_data, .reg_addr, .reg_rd, .reg_wr,
    .reg_bit, .reg_wdata, .conv_load, .conv_data, .mem_din, .cyc_state_r,
    .cyc_phase_r, .ir_r, .opnd_r, .pc_r, .instr_done_r, .decrement_branch_nonzero_result_r,
    .decrement_branch_nonzero_taken_r, .xread_r, .reg_rdata_r, .reg_hit_r, .mem_addr_r,
    .mem_dout_r, .mem_doe_r, .mem_rd_n_r, .mem_wr_n_r,
    .code_read_strobe_n_r, .mem_ale_r, .mem_reset_n_r
  );

  ccs_mem_model ccs_mem_model_inst (
    .ref_clk(ref_clk), .mem_addr(mem_addr_r), .mem_dout(mem_dout_r),
    .mem_doe(mem_doe_r), .rd_n(mem_rd_n_r), .wr_n(mem_wr_n_r),
    .code_n(code_read_strobe_n_r), .ale(mem_ale_r), .mem_din(mem_din),
    .wr_addr(wr_addr), .wr_data(wr_data)
  );

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register request over one edge; strobes stay until the next request
  task automatic reg_op(input logic wr, input logic bt, input logic [7:0] a,
                        input logic [7:0] d);
    reg_wr = wr;
    reg_rd = ~wr;
    reg_bit = bt;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
  endtask

  task automatic wait_done;
    int k;
    k = 0;
    while (instr_done_r !== 1'b1 && k < 40) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 40) begin
      errors++;
      summarize();
    end
  endtask

  // Runs one instruction from a done pulse to the next one
  task automatic run_instr(input logic [1:0] b, input logic [1:0] c,
                           input logic x, input logic xw, input logic dj,
                           input logic [7:0] v);
    logic ph;
    dec_bytes = b;
    dec_cycles = c;
    dec_xmove = x;
    dec_xwrite = xw;
    dec_decrement_branch_nonzero = dj;
    decrement_branch_nonzero_value = v;
    pc0 = pc_r;
    ph = cyc_phase_r;
    n_per = 0;
    n_str = 0;
    n_xl = 0;
    n_ph = 0;
    do begin
      @(negedge ref_clk);
      n_per++;
      if (code_read_strobe_n_r === 1'b0) n_str++;
      if (mem_rd_n_r === 1'b0 || mem_wr_n_r === 1'b0) n_xl++;
      if (cyc_phase_r === ph) n_ph++;
      ph = cyc_phase_r;
    end while (instr_done_r !== 1'b1 && n_per < 60);
    if (n_per >= 60) begin
      errors++;
      summarize();
    end
  endtask

  function automatic logic [7:0] rst_of(input logic [7:0] a);
    if (a[3:0] == 4'h0 && a <= 8'hc0) return CCS_RST_PORT;
    if (a == 8'h81) return CCS_RST_STACK;
    return CCS_RST_ZERO;
  endfunction

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    check("link reset", 16'h1, {15'h0, mem_reset_n_r});
    foreach (rrows[i]) begin
      reg_op(1'b1, 1'b0, rrows[i].a, rrows[i].d);
      reg_op(1'b0, 1'b0, rrows[i].a, 8'h00);
      check("read data", rrows[i].q, reg_rdata_r);
      check("read hit", rrows[i].hit, reg_hit_r);
    end
    wait_done();
    foreach (irows[i]) begin
      run_instr(irows[i].b, irows[i].c, irows[i].x, irows[i].xw, 1'b0, 0);
      check("periods", 16'(irows[i].per), 16'(n_per));
      check("fetches", 16'(irows[i].str), 16'(n_str));
      check("move strobes", 16'(irows[i].xl), 16'(n_xl));
      check("pc step", 16'(irows[i].dpc), pc_r - pc0);
      check("opcode", {8'h00, pc0[7:0] ^ 8'h5a}, ir_r);
      check("state", {CCS_S1, 1'b0}, {cyc_state_r, cyc_phase_r});
      check("phases", 16'h0, 16'(n_ph));
      if (irows[i].x && !irows[i].xw)
        check("move read", 8'h34 ^ 8'h5a, xread_r);
      if (irows[i].xw) begin
        check("move wdata", 16'h00c3, wr_data);
        check("move waddr", 16'h1234, wr_addr);
      end
    end
    run_instr(2'h2, 2'h1, 1'b0, 1'b0, 1'b1, 8'h05);
    o = (pc0[7:0] + 8'h01) ^ 8'h5a;
    check("offset", o, opnd_r);
    check("branch pc", pc0 + 16'h2 + {{8{o[7]}}, o}, pc_r);
    check("decrement", 16'h4, decrement_branch_nonzero_result_r);
    check("taken", 16'h1, {15'h0, decrement_branch_nonzero_taken_r});
    run_instr(2'h2, 2'h1, 1'b0, 1'b0, 1'b1, 8'h01);
    check("fall pc", pc0 + 16'h2, pc_r);
    check("zero", 16'h0, decrement_branch_nonzero_result_r);
    check("not taken", 16'h0, {15'h0, decrement_branch_nonzero_taken_r});
    reg_op(1'b1, 1'b1, 8'h93, 8'h00);
    reg_op(1'b0, 1'b0, 8'h90, 8'h00);
    check("bit clear", 16'h00f7, reg_rdata_r);
    reg_op(1'b1, 1'b1, 8'haf, 8'h01);
    reg_op(1'b0, 1'b0, 8'ha8, 8'h00);
    check("bit set", 16'h0080, reg_rdata_r);
    conv_data = 8'ha7;
    conv_load = 1'b1;
    @(negedge ref_clk);
    conv_load = 1'b0;
    reg_op(1'b0, 1'b0, 8'h96, 8'h00);
    check("result", 16'h00a7, reg_rdata_r);
    reg_op(1'b0, 1'b0, 8'h7f, 8'h00);
    check("low hit", 16'h0, {15'h0, reg_hit_r});
    rstn = 1'b0;
    @(negedge ref_clk);
    check("reset strobe", 16'h1, {15'h0, code_read_strobe_n_r});
    check("reset link", 16'h0, {15'h0, mem_reset_n_r});
    check("pc reset", CCS_PC_RESET, pc_r);
    repeat (11) @(negedge ref_clk);
    rstn = 1'b1;
    foreach (CCS_REG_ADDR[i]) begin
      reg_op(1'b0, 1'b0, CCS_REG_ADDR[i], 8'h00);
      check("reset value", rst_of(CCS_REG_ADDR[i]), reg_rdata_r);
    end
    summarize();
  end
endmodule
